/* File: logic/csw_pkg.sv */
// Constants and types for the control/status and write-protect block
package csw_pkg;

    // Clock and timing
    localparam int CLK_FREQ_KHZ        = 250000;
    localparam int NV_WRITE_MS         = 5;
    localparam int NV_WRITE_CYCLES     = NV_WRITE_MS * CLK_FREQ_KHZ;
    localparam int RESET_UNIT_MS       = 50;
    localparam int RESET_UNIT_CYCLES   = RESET_UNIT_MS * CLK_FREQ_KHZ;
    localparam int CNT_W               = 27;

    // Delay multiples of the 50ms unit per select code
    localparam logic [2:0] DELAY_MULT_00 = 3'h1;
    localparam logic [2:0] DELAY_MULT_01 = 3'h2;
    localparam logic [2:0] DELAY_MULT_10 = 3'h4;
    localparam logic [2:0] DELAY_MULT_11 = 3'h6;

    // Bus decode
    localparam logic [6:0] DEV_SELECT    = 7'h52;
    localparam logic [7:0] REG_OFFSET    = 8'hFF;
    localparam logic [7:0] GLOBAL_ONLY   = 8'h02;

    // Register layout qxyst01r
    localparam int BIT_DSEL_HI  = 7;
    localparam int BIT_FLAG_A   = 6;
    localparam int BIT_FLAG_B   = 5;
    localparam int BIT_LOCK_HI  = 4;
    localparam int BIT_LOCK_LO  = 3;
    localparam int BIT_RWL      = 2;
    localparam int BIT_GWL      = 1;
    localparam int BIT_DSEL_LO  = 0;

    // Values after factory load
    localparam logic [1:0] LOCK_DEFAULT  = 2'h0;
    localparam logic [1:0] DSEL_DEFAULT  = 2'h1;

    // Locked region bases
    localparam logic [7:0] LOCK_QUARTER_BASE = 8'hC0;
    localparam logic [7:0] LOCK_HALF_BASE    = 8'h80;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_DEV      = 4'h1,
        ST_DEV_ACK  = 4'h3,
        ST_ADDR     = 4'h2,
        ST_ADDR_ACK = 4'h6,
        ST_DATA     = 4'h7,
        ST_DATA_ACK = 4'h5,
        ST_READ     = 4'h4,
        ST_SKIP     = 4'hC
    } csw_fsm_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
    } csw_ee_req_s;

    typedef struct packed {
        logic valid;
        logic nonvolatile;
    } csw_dcp_req_s;

    typedef struct packed {
        logic grant;
        logic abort;
    } csw_answer_s;

    typedef struct packed {
        csw_fsm_e             st;
        logic [3:0]           bitcnt;
        logic [7:0]           shreg;
        logic                 scl_q;
        logic                 sda_q;
        logic                 is_read;
        logic                 ack;
        logic                 data_seen;
        logic [7:0]           pend;
        logic                 gwl;
        logic                 rwl;
        logic                 flag_a;
        logic                 flag_b;
        logic [1:0]           lock;
        logic [1:0]           dsel;
        logic                 busy;
        logic [CNT_W-1:0]     nv_cnt;
        csw_answer_s          ee_ans;
        csw_answer_s          dcp_ans;
        logic                 sda_oe_n;
        logic                 sda_o;
    } csw_state_s;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             hold;
    } csw_timer_s;

endpackage

/* File: logic/csw_reset_hold_timer.sv */
// Supply reset hold timer with selectable delay
`timescale 1ns/10ps
module csw_reset_hold_timer #(
    parameter int UNIT_CYCLES = csw_pkg::RESET_UNIT_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Control
    input  wire logic       supply_ok_in,
    input  wire logic [1:0] delay_sel_in,
    // Status
    output logic            hold_out
);
    import csw_pkg::*;

    csw_timer_s             s_reg;
    csw_timer_s             s_next;
    logic [2:0]             mult;
    logic [CNT_W-1:0]       target;

    always_comb begin
        case (delay_sel_in)
            2'h0:    mult = DELAY_MULT_00;
            2'h1:    mult = DELAY_MULT_01;
            2'h2:    mult = DELAY_MULT_10;
            2'h3:    mult = DELAY_MULT_11;
            default: mult = DELAY_MULT_01;
        endcase
        target = CNT_W'(UNIT_CYCLES * int'(mult));
        s_next = s_reg;
        if (!supply_ok_in) begin
            // Any dip restarts the full delay
            s_next.cnt  = '0;
            s_next.hold = 1'b1;
        end else if (s_reg.cnt >= target - CNT_W'(1)) begin
            s_next.hold = 1'b0;
        end else begin
            s_next.cnt  = s_reg.cnt + CNT_W'(1);
            s_next.hold = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_reg <= '{cnt: '0, hold: 1'b1};
        end else begin
            s_reg <= s_next;
        end
    end

    assign hold_out = s_reg.hold;

endmodule

/* File: logic/csw_control_status.sv */
// Control/status register, 2-wire register access and write permission
`timescale 1ns/10ps
module csw_control_status #(
    parameter int NV_CYCLES    = csw_pkg::NV_WRITE_CYCLES,
    parameter int UNIT_CYCLES  = csw_pkg::RESET_UNIT_CYCLES
) (
    // Clock and power-cycle reset
    input  wire logic           clk_in,
    input  wire logic           rst_in,
    input  wire logic           factory_load_in,
    // 2-wire bus
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe_n_out,
    // Protection and monitors
    input  wire logic           write_protect_in,
    input  wire logic           supply_ok_in,
    input  wire logic           monitor_a_reset_output_in,
    input  wire logic           monitor_b_reset_output_in,
    // Write permission requests
    input  wire csw_pkg::csw_ee_req_s  ee_req_in,
    input  wire csw_pkg::csw_dcp_req_s dcp_req_in,
    output csw_pkg::csw_answer_s       ee_ans_out,
    output csw_pkg::csw_answer_s       dcp_ans_out,
    // Status
    output logic [7:0]          control_status_out,
    output logic                busy_out,
    output logic                supply_reset_output_out
);
    import csw_pkg::*;

    csw_state_s     s_reg;
    csw_state_s     s_next;
    logic [7:0]     csr;
    logic [7:0]     byte_in;
    logic           scl_rise;
    logic           scl_fall;
    logic           bus_start;
    logic           bus_stop;
    logic           data_ok;
    logic           ee_locked;
    logic           hold;

    csw_reset_hold_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_timer (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .supply_ok_in (supply_ok_in),
        .delay_sel_in (s_reg.dsel),
        .hold_out     (hold)
    );

    // qxyst01r view of the register
    always_comb begin
        csr = '0;
        csr[BIT_DSEL_HI] = s_reg.dsel[1];
        csr[BIT_FLAG_A]  = s_reg.flag_a;
        csr[BIT_FLAG_B]  = s_reg.flag_b;
        csr[BIT_LOCK_HI] = s_reg.lock[1];
        csr[BIT_LOCK_LO] = s_reg.lock[0];
        csr[BIT_RWL]     = s_reg.rwl;
        csr[BIT_GWL]     = s_reg.gwl;
        csr[BIT_DSEL_LO] = s_reg.dsel[0];
    end

    assign byte_in   = {s_reg.shreg[6:0], sda_in};
    assign scl_rise  = scl_in & ~s_reg.scl_q;
    assign scl_fall  = ~scl_in & s_reg.scl_q;
    assign bus_start = scl_in & s_reg.scl_q & s_reg.sda_q & ~sda_in;
    assign bus_stop  = scl_in & s_reg.scl_q & ~s_reg.sda_q & sda_in;

    // Decision on the single data byte
    always_comb begin
        if (s_reg.busy) begin
            data_ok = 1'b0;
        end else if (byte_in[BIT_RWL]) begin
            data_ok = s_reg.gwl;
        end else if (s_reg.rwl && s_reg.gwl) begin
            data_ok = ~write_protect_in;
        end else begin
            // Only 00h/02h may touch the global latch on its own
            data_ok = ((byte_in & ~GLOBAL_ONLY) == 8'h00);
        end
    end

    always_comb begin
        case (s_reg.lock)
            2'h0:    ee_locked = 1'b0;
            2'h1:    ee_locked = (ee_req_in.addr >= LOCK_QUARTER_BASE);
            2'h2:    ee_locked = (ee_req_in.addr >= LOCK_HALF_BASE);
            2'h3:    ee_locked = 1'b1;
            default: ee_locked = 1'b1;
        endcase
    end

    always_comb begin
        s_next       = s_reg;
        s_next.scl_q = scl_in;
        s_next.sda_q = sda_in;
        s_next.sda_o = 1'b0;

        // Bus engine
        if (bus_start) begin
            s_next.st        = ST_DEV;
            s_next.bitcnt    = '0;
            s_next.data_seen = 1'b0;
            s_next.sda_oe_n  = 1'b1;
        end else if (bus_stop) begin
            s_next.st       = ST_IDLE;
            s_next.sda_oe_n = 1'b1;
            // One acked byte, then only the STOP's own clock rise
            if (!s_reg.is_read
                && s_reg.data_seen && s_reg.st == ST_DATA
                && s_reg.bitcnt == 4'h1) begin
                if (s_reg.pend[BIT_RWL]) begin
                    s_next.gwl = 1'b1;
                    s_next.rwl = 1'b1;
                end else if (s_reg.rwl && s_reg.gwl) begin
                    s_next.flag_a = s_reg.pend[BIT_FLAG_A]
                                    & monitor_a_reset_output_in;
                    s_next.flag_b = s_reg.pend[BIT_FLAG_B]
                                    & monitor_b_reset_output_in;
                    s_next.lock   = s_reg.pend[BIT_LOCK_HI:BIT_LOCK_LO];
                    s_next.dsel   = {s_reg.pend[BIT_DSEL_HI],
                                     s_reg.pend[BIT_DSEL_LO]};
                    s_next.gwl    = s_reg.pend[BIT_GWL];
                    s_next.busy   = 1'b1;
                    s_next.nv_cnt = '0;
                end else begin
                    s_next.gwl = s_reg.pend[BIT_GWL];
                end
            end
        end else begin
            case (s_reg.st)
                ST_DEV, ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        s_next.shreg  = byte_in;
                        s_next.bitcnt = s_reg.bitcnt + 4'h1;
                        if (s_reg.bitcnt == 4'h7) begin
                            s_next.bitcnt = '0;
                            if (s_reg.st == ST_DEV) begin
                                s_next.st      = ST_DEV_ACK;
                                s_next.is_read = byte_in[0];
                                s_next.ack     = (byte_in[7:1]
                                                  == DEV_SELECT);
                            end else if (s_reg.st == ST_ADDR) begin
                                s_next.st  = ST_ADDR_ACK;
                                s_next.ack = (byte_in == REG_OFFSET);
                            end else begin
                                s_next.st  = ST_DATA_ACK;
                                s_next.ack = ~s_reg.data_seen & data_ok;
                                if (!s_reg.data_seen && data_ok) begin
                                    s_next.pend      = byte_in;
                                    s_next.data_seen = 1'b1;
                                end else begin
                                    s_next.data_seen = 1'b0;
                                end
                            end
                        end
                    end
                end
                ST_DEV_ACK, ST_ADDR_ACK, ST_DATA_ACK: begin
                    if (scl_fall && s_reg.bitcnt == 4'h0) begin
                        s_next.bitcnt   = 4'h1;
                        s_next.sda_oe_n = ~s_reg.ack;
                    end else if (scl_fall) begin
                        s_next.bitcnt   = '0;
                        s_next.sda_oe_n = 1'b1;
                        if (!s_reg.ack) begin
                            s_next.st = ST_SKIP;
                        end else if (s_reg.st == ST_DEV_ACK
                                     && s_reg.is_read) begin
                            // Send bit 7 now, rest on later falls
                            s_next.st       = ST_READ;
                            s_next.sda_oe_n = csr[7];
                            s_next.shreg    = {csr[6:0], 1'b0};
                            s_next.bitcnt   = 4'h1;
                        end else if (s_reg.st == ST_DEV_ACK) begin
                            s_next.st = ST_ADDR;
                        end else begin
                            s_next.st = ST_DATA;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall && s_reg.bitcnt == 4'h8) begin
                        // One byte only, then ignore until next START
                        s_next.sda_oe_n = 1'b1;
                        s_next.st       = ST_SKIP;
                    end else if (scl_fall) begin
                        s_next.sda_oe_n = s_reg.shreg[7];
                        s_next.shreg    = {s_reg.shreg[6:0], 1'b0};
                        s_next.bitcnt   = s_reg.bitcnt + 4'h1;
                    end
                end
                ST_IDLE, ST_SKIP: begin
                    s_next.sda_oe_n = 1'b1;
                end
                default: begin
                    s_next.st       = ST_IDLE;
                    s_next.sda_oe_n = 1'b1;
                end
            endcase
        end

        // Nonvolatile cycle timing
        if (s_reg.busy) begin
            s_next.nv_cnt = s_reg.nv_cnt + CNT_W'(1);
            if (s_reg.nv_cnt >= CNT_W'(NV_CYCLES - 1)) begin
                s_next.busy = 1'b0;
                s_next.rwl  = 1'b0;
            end
        end

        // Array write permission
        s_next.ee_ans = '0;
        if (ee_req_in.valid) begin
            s_next.ee_ans.grant = s_reg.gwl & ~write_protect_in
                                  & ~ee_locked & ~s_reg.busy;
            s_next.ee_ans.abort = ~(s_reg.gwl & ~write_protect_in
                                  & ~ee_locked & ~s_reg.busy);
            // A latch set by a commit in this same cycle wins
            if (ee_locked && s_next.rwl == s_reg.rwl) begin
                s_next.rwl = 1'b0;
            end
        end

        // Wiper write permission
        s_next.dcp_ans = '0;
        if (dcp_req_in.valid) begin
            s_next.dcp_ans.grant = s_reg.gwl & (s_reg.lock == 2'h0)
                & ~(dcp_req_in.nonvolatile & write_protect_in)
                & ~s_reg.busy;
            s_next.dcp_ans.abort = ~(s_reg.gwl & (s_reg.lock == 2'h0)
                & ~(dcp_req_in.nonvolatile & write_protect_in)
                & ~s_reg.busy);
        end

        // Flags follow their monitor outputs down
        s_next.flag_a = s_next.flag_a & monitor_a_reset_output_in;
        s_next.flag_b = s_next.flag_b & monitor_b_reset_output_in;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // Power cycle: volatile state to zero, bus samples and SDA release high, lock/delay bits kept unless factory load
            s_reg          <= '0;
            s_reg.st       <= ST_IDLE;
            s_reg.scl_q    <= 1'b1;
            s_reg.sda_q    <= 1'b1;
            s_reg.sda_oe_n <= 1'b1;
            s_reg.lock     <= factory_load_in ? LOCK_DEFAULT
                                              : s_reg.lock;
            s_reg.dsel     <= factory_load_in ? DSEL_DEFAULT
                                              : s_reg.dsel;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sda_out                 = s_reg.sda_o;
    assign sda_oe_n_out            = s_reg.sda_oe_n;
    assign ee_ans_out              = s_reg.ee_ans;
    assign dcp_ans_out             = s_reg.dcp_ans;
    assign control_status_out      = csr;
    assign busy_out                = s_reg.busy;
    assign supply_reset_output_out = hold;

endmodule

/* File: testbench/csw_control_status_properties.sv */
// Port-level assertions for the control/status and write-protect block
`timescale 1ns/10ps
module csw_control_status_properties #(
    parameter int NV_CYCLES = 20
) (
    // Clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    // Inputs watched
    input  wire logic                  write_protect_in,
    input  wire logic                  supply_ok_in,
    input  wire logic                  monitor_a_reset_output_in,
    input  wire csw_pkg::csw_ee_req_s  ee_req_in,
    input  wire csw_pkg::csw_dcp_req_s dcp_req_in,
    // Outputs watched
    input  wire csw_pkg::csw_answer_s  ee_ans_out,
    input  wire csw_pkg::csw_answer_s  dcp_ans_out,
    input  wire logic [7:0]            control_status_out,
    input  wire logic                  busy_out,
    input  wire logic                  supply_reset_output_out
);
    import csw_pkg::*;
    logic [1:0] lock;
    logic       locked;
    int         busy_len_reg;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    assign lock = control_status_out[4:3];
    assign locked = lock == 2'h3 || (lock == 2'h2 && ee_req_in.addr[7])
        || (lock == 2'h1 && ee_req_in.addr[7:6] == 2'h3);
    // Length of the running nonvolatile cycle, compared when busy drops
    always_ff @(posedge clk_in) begin
        if (rst_in || !busy_out) begin
            busy_len_reg <= 0;
        end else begin
            busy_len_reg <= busy_len_reg + 1;
        end
    end
    sequence s_ee_req;
        ee_req_in.valid;
    endsequence
    sequence s_nv_end;
        $fell(busy_out);
    endsequence
    property p_ee_answer;
        s_ee_req |=> ee_ans_out.grant ^ ee_ans_out.abort;
    endproperty
    a_ee_answer: assert property (p_ee_answer)
        else $error("array request not answered once");
    property p_no_gwl;
        ee_req_in.valid && !control_status_out[1] |=> ee_ans_out.abort;
    endproperty
    a_no_gwl: assert property (p_no_gwl)
        else $error("array write allowed with global latch clear");
    property p_wp;
        ee_req_in.valid && write_protect_in |=> ee_ans_out.abort;
    endproperty
    a_wp: assert property (p_wp)
        else $error("array write allowed with write protect high");
    property p_lock;
        ee_req_in.valid && locked |=> ee_ans_out.abort;
    endproperty
    a_lock: assert property (p_lock)
        else $error("array write allowed into locked region");
    property p_dcp_lock;
        dcp_req_in.valid && lock != 2'h0 |=> dcp_ans_out.abort;
    endproperty
    a_dcp_lock: assert property (p_dcp_lock)
        else $error("wiper write allowed with lock set");
    property p_busy_deny;
        ee_req_in.valid && busy_out |=> ee_ans_out.abort;
    endproperty
    a_busy_deny: assert property (p_busy_deny)
        else $error("array write allowed during busy");
    property p_flag_clear;
        !monitor_a_reset_output_in |=> !control_status_out[6];
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("monitor flag kept with monitor output low");
    property p_nv_len;
        s_nv_end |-> busy_len_reg == NV_CYCLES && !control_status_out[2];
    endproperty
    a_nv_len: assert property (p_nv_len)
        else $error("nonvolatile cycle length or latch clear wrong");
    property p_supply_hold;
        !supply_ok_in |=> supply_reset_output_out;
    endproperty
    a_supply_hold: assert property (p_supply_hold)
        else $error("supply reset output low while supply bad");
endmodule

bind csw_control_status csw_control_status_properties #(
    .NV_CYCLES(NV_CYCLES)
) i_csw_control_status_properties (
    .clk_in, .rst_in, .write_protect_in, .supply_ok_in,
    .monitor_a_reset_output_in, .ee_req_in, .dcp_req_in, .ee_ans_out,
    .dcp_ans_out, .control_status_out, .busy_out, .supply_reset_output_out
);

/* File: testbench/csw_bus_master.sv */
// Behavioural 2-wire bus master driving the block's register port
`timescale 1ns/10ps
module csw_bus_master (
    // Clock
    input  wire logic clk_in,
    // Bus wire level and drive, 1 releases the line to its pull-up
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    // Clock stands high between frames
    initial begin
        scl_out = 1'h1;
        sda_out = 1'h1;
    end
    // Four clocks per phase, four times the minimum the block needs
    task automatic hp();
        repeat (4) @(negedge clk_in);
    endtask
    task automatic start();
        sda_out = 1'h1;
        hp();
        scl_out = 1'h1;
        hp();
        sda_out = 1'h0;
        hp();
        scl_out = 1'h0;
        hp();
    endtask
    task automatic stop();
        sda_out = 1'h0;
        hp();
        scl_out = 1'h1;
        hp();
        sda_out = 1'h1;
        hp();
    endtask
    // Data only moves while the clock is low, else it reads as START/STOP
    task automatic clk_bit(input logic b, output logic seen);
        sda_out = b;
        hp();
        scl_out = 1'h1;
        hp();
        seen = sda_in;
        scl_out = 1'h0;
        hp();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'h1, s);
        ack = ~s;
    endtask
    task automatic rbyte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'h1, s);
            d[i] = s;
        end
        clk_bit(1'h1, s);
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the control/status and write-protect block
`timescale 1ns/10ps
module tb_top;
    import csw_pkg::*;
    localparam int NV   = 20;
    localparam int UNIT = 10;
    logic         clk_in, rst_in, fl, wp, sup_ok, mon_a, mon_b, scl, m_sda;
    logic         d_sda, d_oe_n, busy, sup_rst;
    logic [7:0]   csr;
    csw_ee_req_s  ee_req;
    csw_dcp_req_s dcp_req;
    csw_answer_s  ee_ans, dcp_ans;
    int           errors = 0;
    int           compares = 0;
    wire logic    sda_line;
    assign sda_line = m_sda & (d_oe_n | d_sda);
    csw_control_status #(.NV_CYCLES(NV), .UNIT_CYCLES(UNIT))
    i_csw_control_status (.clk_in(clk_in), .rst_in(rst_in),
        .factory_load_in(fl), .scl_in(scl), .sda_in(sda_line),
        .sda_out(d_sda), .sda_oe_n_out(d_oe_n), .write_protect_in(wp),
        .supply_ok_in(sup_ok), .monitor_a_reset_output_in(mon_a),
        .monitor_b_reset_output_in(mon_b), .ee_req_in(ee_req),
        .dcp_req_in(dcp_req), .ee_ans_out(ee_ans), .dcp_ans_out(dcp_ans),
        .control_status_out(csr), .busy_out(busy),
        .supply_reset_output_out(sup_rst));
    csw_bus_master i_csw_bus_master (.clk_in(clk_in), .sda_in(sda_line),
        .scl_out(scl), .sda_out(m_sda));
    initial begin
        clk_in = 1'h0;
        forever #2 clk_in = ~clk_in;
    end
    task automatic tally_and_finish();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] got,
                         input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stuck(input string what);
        errors++;
        $display("timeout waiting for %s", what);
        tally_and_finish();
    endtask
    task automatic power_cycle(input logic load);
        @(negedge clk_in);
        rst_in = 1'h1;
        fl = load;
        sup_ok = 1'h0;
        repeat (4) @(negedge clk_in);
        rst_in = 1'h0;
        fl = 1'h0;
        repeat (2) @(negedge clk_in);
    endtask
    // Counts clocks from supply good until the reset output drops
    task automatic hold_time(input int exp);
        int n;
        n = 0;
        sup_ok = 1'h1;
        while (sup_rst === 1'h1 && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 400) stuck("reset release");
        check("hold window", n >= exp && n <= exp + 2, 8'h01);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        if (n >= 100) stuck("busy clear");
    endtask
    task automatic probe(input logic [7:0] a, input logic nv,
                         input logic eg, input logic dg);
        @(negedge clk_in);
        ee_req = '{valid: 1'h1, addr: a};
        dcp_req = '{valid: 1'h1, nonvolatile: nv};
        @(negedge clk_in);
        ee_req = '0;
        dcp_req = '0;
        check("array grant", ee_ans.grant, eg);
        check("array abort", ee_ans.abort, !eg);
        check("wiper grant", dcp_ans.grant, dg);
        check("wiper abort", dcp_ans.abort, !dg);
    endtask
    task automatic wr(input logic [7:0] d, input logic e);
        logic a;
        i_csw_bus_master.start();
        i_csw_bus_master.wbyte(8'hA4, a);
        check("select ack", a, 1'h1);
        i_csw_bus_master.wbyte(8'hFF, a);
        check("offset ack", a, 1'h1);
        i_csw_bus_master.wbyte(d, a);
        check("data ack", a, e);
        i_csw_bus_master.stop();
    endtask
    task automatic reg_rd(input logic [7:0] exp);
        logic       a;
        logic [7:0] d;
        i_csw_bus_master.start();
        i_csw_bus_master.wbyte(8'hA4, a);
        i_csw_bus_master.wbyte(8'hFF, a);
        i_csw_bus_master.start();
        i_csw_bus_master.wbyte(8'hA5, a);
        check("read select ack", a, 1'h1);
        i_csw_bus_master.rbyte(d);
        i_csw_bus_master.stop();
        check("read data", d, exp);
    endtask
    task automatic set_reg(input logic [7:0] d);
        wr(8'h02, 1'h1);
        wr(8'h06, 1'h1);
        wr(d, 1'h1);
        check("busy", busy, 1'h1);
        probe(8'h00, 1'h0, 1'h0, 1'h0);
        wait_idle();
    endtask
    task automatic test_reset();
        power_cycle(1'h1);
        check("csr", csr, 8'h01);
        check("reset out", sup_rst, 1'h1);
        hold_time(2 * UNIT);
        $display("test_reset done");
    endtask
    task automatic test_refused();
        logic a;
        wr(8'h06, 1'h0);
        check("csr", csr, 8'h01);
        probe(8'h10, 1'h0, 1'h0, 1'h0);
        i_csw_bus_master.start();
        i_csw_bus_master.wbyte(8'hA6, a);
        check("foreign select ack", a, 1'h0);
        i_csw_bus_master.stop();
        $display("test_refused done");
    endtask
    task automatic test_update();
        wr(8'h02, 1'h1);
        check("csr", csr, 8'h03);
        wr(8'h06, 1'h1);
        check("csr", csr, 8'h07);
        reg_rd(8'h07);
        check("csr", csr, 8'h07);
        wr(8'hEB, 1'h1);
        wait_idle();
        check("csr", csr, 8'hCB);
        mon_a = 1'h0;
        repeat (2) @(negedge clk_in);
        check("csr", csr, 8'h8B);
        power_cycle(1'h0);
        mon_a = 1'h1;
        check("csr", csr, 8'h89);
        hold_time(6 * UNIT);
        $display("test_update done");
    endtask
    task automatic test_lock();
        logic [7:0] pa [6] = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF};
        logic       lk;
        for (int k = 0; k < 4; k++) begin
            set_reg({3'h0, k[1:0], 3'h3});
            check("csr", csr, {3'h0, k[1:0], 3'h3});
            foreach (pa[i]) begin
                lk = k == 3 || (k == 2 && pa[i][7])
                     || (k == 1 && pa[i] > 8'hBF);
                probe(pa[i], 1'h1, !lk, k == 0);
            end
            wp = 1'h1;
            probe(8'h00, 1'h0, 1'h0, k == 0);
            probe(8'h00, 1'h1, 1'h0, 1'h0);
            wp = 1'h0;
        end
        wr(8'h02, 1'h1);
        wr(8'h06, 1'h1);
        probe(8'h40, 1'h0, 1'h0, 1'h0);
        @(negedge clk_in);
        check("register latch", csr[2], 1'h0);
        $display("test_lock done");
    endtask
    task automatic test_guard();
        logic a;
        wr(8'h06, 1'h1);
        wr(8'hFE, 1'h1);
        check("csr", csr, 8'h1F);
        check("busy", busy, 1'h0);
        wp = 1'h1;
        wr(8'h03, 1'h0);
        wp = 1'h0;
        check("csr", csr, 8'h1F);
        i_csw_bus_master.start();
        i_csw_bus_master.wbyte(8'hA4, a);
        i_csw_bus_master.wbyte(8'hFF, a);
        i_csw_bus_master.wbyte(8'h03, a);
        check("first ack", a, 1'h1);
        i_csw_bus_master.wbyte(8'h03, a);
        check("second ack", a, 1'h0);
        i_csw_bus_master.stop();
        check("busy", busy, 1'h0);
        check("csr", csr, 8'h1F);
        $display("test_guard done");
    endtask
    initial begin
        rst_in = 1'h1;
        fl = 1'h1;
        wp = 1'h0;
        sup_ok = 1'h0;
        mon_a = 1'h1;
        mon_b = 1'h0;
        ee_req = '0;
        dcp_req = '0;
        test_reset();
        test_refused();
        test_update();
        test_lock();
        test_guard();
        tally_and_finish();
    end
endmodule
